// >>> hw/fsc_pkg.sv
`default_nettype none

package fsc_pkg;

    localparam int DATA_W = 9;
    // Pointers are sized for the largest buffer plus one wrap bit
    localparam int PTR_W = 14;
    localparam int OFS_W = 9;
    localparam int NUM_CHAN = 2;
    localparam int DEF_DEPTH = 256;

    localparam logic [OFS_W-1:0] AE_OFS_RST = 9'h007;
    localparam logic [OFS_W-1:0] AF_OFS_RST = 9'h007;
    localparam logic [DATA_W-1:0] DATA_RST = 9'h000;
    localparam logic [PTR_W-1:0] PTR_RST = 14'h0000;
    localparam logic [PTR_W-1:0] PTR_ONE = 14'h0001;

    // Offset-register access order: almost-empty first, then almost-full
    localparam logic OFS_SEL_AE = 1'b0;
    localparam logic OFS_SEL_AF = 1'b1;

    // Channel-side pin levels, sampled together so they stay aligned
    typedef struct packed {
        logic wclk;
        logic rclk;
        logic we1_n;
        logic we2_ld;
        logic re1_n;
        logic re2_n;
        logic oe_n;
        logic rst_n;
        logic [DATA_W-1:0] wdata;
    } fsc_pins_t;

    typedef struct packed {
        logic empty_n;
        logic full_n;
        logic almost_empty_n;
        logic almost_full_n;
    } fsc_flags_t;

    typedef struct packed {
        fsc_pins_t s1;
        fsc_pins_t s2;
        fsc_pins_t prev;
        logic mode_dual;
        logic ofs_sel_w;
        logic ofs_sel_r;
        logic [OFS_W-1:0] ae_ofs;
        logic [OFS_W-1:0] af_ofs;
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] rptr;
        logic [PTR_W-1:0] wgray;
        logic [PTR_W-1:0] rgray;
        logic [PTR_W-1:0] wgray_s1;
        logic [PTR_W-1:0] wgray_s2;
        logic [PTR_W-1:0] rgray_s1;
        logic [PTR_W-1:0] rgray_s2;
        logic rd_pend;
        logic [DATA_W-1:0] q;
        logic oe;
        fsc_flags_t flags;
    } fsc_chan_st_t;

    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

endpackage : fsc_pkg

`default_nettype wire

// >>> hw/fsc_ram.sv
`default_nettype none

module fsc_ram #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk_sys_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [fsc_pkg::DATA_W-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [fsc_pkg::DATA_W-1:0] rd_data_o
);

    logic [fsc_pkg::DATA_W-1:0] mem [DEPTH];
    logic [fsc_pkg::DATA_W-1:0] rd_data_r;

    // No reset on the array so it maps onto block memory
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i) begin
            rd_data_r <= mem[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_r;

endmodule : fsc_ram

`default_nettype wire

// >>> hw/fsc_dual_fifo.sv
// Behaviour
// [RL1] Each channel takes and returns 9-bit words; channels A and B are independent.
// [RL2] Dual-role pin level at reset picks second-write-enable or offset-load mode.
// [RL3] Offset-load mode: write when primary enable low and full flag high.
// [RL4] Dual-enable mode: write when primary low, second high, full flag high.
// [RL5] Writes while full flag is low are ignored; contents stay unchanged.
// [RL6] Load held low: qualified write edge stores data into the offset register.
// [RL7] Load held low: qualified read edge returns offset register on data outputs.
// [RL8] Read advances only with both read enables low and channel not empty.
// [RL9] Empty flag low when no words held, updated on the read side.
// [RL10] Full flag low when no free location, updated on the write side.
// [RL11] Almost-empty flag low when word count reaches programmed offset.
// [RL12] Almost-full flag low when free space reaches programmed offset.
// [RL13] Channel reset returns it to empty, clearing the word count.
// [RL14] Controller resets each channel after power-up before first access.
// [RL15] Output enable low drives data outputs; high releases them.
// [RL16] Depth per channel is a build parameter, 256 to 8192, same for both.
// [RL17] Flags come from gray-coded pointers passed through two-stage synchronisers.
`default_nettype none

module fsc_dual_fifo #(
    parameter int DEPTH = fsc_pkg::DEF_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic chan_a_write_clock_i,
    input wire logic chan_a_read_clock_i,
    input wire logic [fsc_pkg::DATA_W-1:0] chan_a_write_data_i,
    input wire logic chan_a_write_en_primary_n_i,
    input wire logic chan_a_write_en2_or_load_i,
    input wire logic chan_a_read_en_first_n_i,
    input wire logic chan_a_read_en_second_n_i,
    input wire logic chan_a_output_en_n_i,
    input wire logic chan_a_reset_n_i,
    output logic [fsc_pkg::DATA_W-1:0] chan_a_read_data_o,
    output logic chan_a_read_data_oe_o,
    output logic chan_a_empty_n_o,
    output logic chan_a_full_n_o,
    output logic chan_a_almost_empty_n_o,
    output logic chan_a_almost_full_n_o,
    input wire logic chan_b_write_clock_i,
    input wire logic chan_b_read_clock_i,
    input wire logic [fsc_pkg::DATA_W-1:0] chan_b_write_data_i,
    input wire logic chan_b_write_en_primary_n_i,
    input wire logic chan_b_write_en2_or_load_i,
    input wire logic chan_b_read_en_first_n_i,
    input wire logic chan_b_read_en_second_n_i,
    input wire logic chan_b_output_en_n_i,
    input wire logic chan_b_reset_n_i,
    output logic [fsc_pkg::DATA_W-1:0] chan_b_read_data_o,
    output logic chan_b_read_data_oe_o,
    output logic chan_b_empty_n_o,
    output logic chan_b_full_n_o,
    output logic chan_b_almost_empty_n_o,
    output logic chan_b_almost_full_n_o
);

    // Legal depths are the powers of two from 256 to 8192 [RL16]
    localparam int AW = $clog2(DEPTH);
    localparam logic [fsc_pkg::PTR_W-1:0] DEPTH_P = fsc_pkg::PTR_W'(DEPTH);
    localparam logic [fsc_pkg::PTR_W-1:0] PTR_MASK = fsc_pkg::PTR_W'(2 * DEPTH - 1);
    localparam logic [fsc_pkg::PTR_W-1:0] ADDR_MASK = fsc_pkg::PTR_W'(DEPTH - 1);

    // Sync stages restart at idle pin levels: no false edge, enable or mode strap
    localparam fsc_pkg::fsc_pins_t PINS_IDLE = '{
        wclk: 1'b0,
        rclk: 1'b0,
        we1_n: 1'b1,
        we2_ld: 1'b1,
        re1_n: 1'b1,
        re2_n: 1'b1,
        oe_n: 1'b1,
        rst_n: 1'b0,
        wdata: fsc_pkg::DATA_RST
    };

    // Reset flag levels: empty and almost empty, with room to write
    localparam fsc_pkg::fsc_flags_t FLAGS_RST = '{
        empty_n: 1'b0,
        full_n: 1'b1,
        almost_empty_n: 1'b0,
        almost_full_n: 1'b1
    };

    fsc_pkg::fsc_pins_t pins_in [fsc_pkg::NUM_CHAN];
    fsc_pkg::fsc_chan_st_t st_out [fsc_pkg::NUM_CHAN];

    // Pin bundles let one generate body serve both channels
    assign pins_in[0] = '{
        wclk: chan_a_write_clock_i,
        rclk: chan_a_read_clock_i,
        we1_n: chan_a_write_en_primary_n_i,
        we2_ld: chan_a_write_en2_or_load_i,
        re1_n: chan_a_read_en_first_n_i,
        re2_n: chan_a_read_en_second_n_i,
        oe_n: chan_a_output_en_n_i,
        rst_n: chan_a_reset_n_i,
        wdata: chan_a_write_data_i
    };

    assign pins_in[1] = '{
        wclk: chan_b_write_clock_i,
        rclk: chan_b_read_clock_i,
        we1_n: chan_b_write_en_primary_n_i,
        we2_ld: chan_b_write_en2_or_load_i,
        re1_n: chan_b_read_en_first_n_i,
        re2_n: chan_b_read_en_second_n_i,
        oe_n: chan_b_output_en_n_i,
        rst_n: chan_b_reset_n_i,
        wdata: chan_b_write_data_i
    };

    // Each channel is a private copy with no shared state [RL1]
    for (genvar g = 0; g < fsc_pkg::NUM_CHAN; g++) begin : g_chan
        fsc_pkg::fsc_chan_st_t st_r;
        fsc_pkg::fsc_chan_st_t st_nxt;
        logic wr_go;
        logic rd_go;
        logic [fsc_pkg::DATA_W-1:0] ram_rdata;

        // Memory data lands one clock after the read strobe, hence rd_pend
        fsc_ram #(
            .DEPTH(DEPTH),
            .AW(AW)
        ) u_ram (
            .clk_sys_i(clk_sys_i),
            .wr_en_i(wr_go),
            .wr_addr_i(AW'(st_r.wptr & ADDR_MASK)),
            .wr_data_i(st_r.s2.wdata),
            .rd_en_i(rd_go),
            .rd_addr_i(AW'(st_r.rptr & ADDR_MASK)),
            .rd_data_o(ram_rdata)
        );

        always_comb begin
            logic wrise;
            logic rrise;
            logic chan_rst;
            logic loading;
            logic wr_qual;
            logic rd_qual;
            logic [fsc_pkg::PTR_W-1:0] wbin_sync;
            logic [fsc_pkg::PTR_W-1:0] rbin_sync;
            logic [fsc_pkg::PTR_W-1:0] used_w;
            logic [fsc_pkg::PTR_W-1:0] used_r;
            logic [fsc_pkg::PTR_W-1:0] free_w;
            wrise = 1'b0;
            rrise = 1'b0;
            chan_rst = 1'b0;
            loading = 1'b0;
            wr_qual = 1'b0;
            rd_qual = 1'b0;
            wbin_sync = '0;
            rbin_sync = '0;
            used_w = '0;
            used_r = '0;
            free_w = '0;
            wr_go = 1'b0;
            rd_go = 1'b0;
            st_nxt = st_r;

            // Pins come from other clocks; logic only looks at stage two
            st_nxt.s1 = pins_in[g];
            st_nxt.s2 = st_r.s1;
            st_nxt.prev = st_r.s2;
            // Edges are found on the synced copy, so pins need one sampled clock high and one low
            wrise = st_r.s2.wclk & ~st_r.prev.wclk;
            rrise = st_r.s2.rclk & ~st_r.prev.rclk;
            chan_rst = ~st_r.s2.rst_n;

            // Offset access only exists in the programmable-flag mode [RL6] [RL7]
            loading = ~st_r.mode_dual & ~st_r.s2.we2_ld;
            if (st_r.mode_dual) begin
                wr_qual = ~st_r.s2.we1_n & st_r.s2.we2_ld; // [RL4]
            end else begin
                wr_qual = ~st_r.s2.we1_n; // [RL3]
            end
            // Both read enables must be low; either one alone parks the read side
            rd_qual = ~st_r.s2.re1_n & ~st_r.s2.re2_n;

            // Offset writes never touch the buffer, so the full flag does not gate them
            if (wrise && wr_qual && loading) begin
                if (st_r.ofs_sel_w == fsc_pkg::OFS_SEL_AE) begin
                    st_nxt.ae_ofs = st_r.s2.wdata; // [RL6]
                end else begin
                    st_nxt.af_ofs = st_r.s2.wdata; // [RL6]
                end
                st_nxt.ofs_sel_w = ~st_r.ofs_sel_w;
            end else if (wrise && wr_qual && st_r.flags.full_n) begin
                // A low full flag blocks the store entirely [RL5]
                wr_go = 1'b1; // [RL3] [RL4] [RL5]
                st_nxt.wptr = (st_r.wptr + fsc_pkg::PTR_ONE) & PTR_MASK;
            end

            st_nxt.rd_pend = 1'b0;
            // Offset reads ignore the empty flag and answer one clock before buffer data
            if (rrise && rd_qual && loading) begin
                if (st_r.ofs_sel_r == fsc_pkg::OFS_SEL_AE) begin
                    st_nxt.q = st_r.ae_ofs; // [RL7]
                end else begin
                    st_nxt.q = st_r.af_ofs; // [RL7]
                end
                st_nxt.ofs_sel_r = ~st_r.ofs_sel_r;
            end else if (rrise && rd_qual && st_r.flags.empty_n) begin
                rd_go = 1'b1; // [RL8]
                st_nxt.rd_pend = 1'b1;
                st_nxt.rptr = (st_r.rptr + fsc_pkg::PTR_ONE) & PTR_MASK;
            end
            if (st_r.rd_pend) begin
                st_nxt.q = ram_rdata; // [RL1] [RL8]
            end

            // Enable is a plain synced copy; the data word keeps its value meanwhile
            st_nxt.oe = ~st_r.s2.oe_n; // [RL15]

            // Gray pointers cross with two stages, as they would between real domains
            st_nxt.wgray = fsc_pkg::bin2gray(st_nxt.wptr); // [RL17]
            st_nxt.rgray = fsc_pkg::bin2gray(st_nxt.rptr); // [RL17]
            st_nxt.wgray_s1 = st_r.wgray; // [RL17]
            st_nxt.wgray_s2 = st_r.wgray_s1;
            st_nxt.rgray_s1 = st_r.rgray; // [RL17]
            st_nxt.rgray_s2 = st_r.rgray_s1;
            wbin_sync = fsc_pkg::gray2bin(st_r.wgray_s2);
            rbin_sync = fsc_pkg::gray2bin(st_r.rgray_s2);

            // Offsets are 9 bits wide: on deep buffers the almost flags only guard the ends
            // Read-side flags see the write pointer late, so they err toward empty
            used_r = (wbin_sync - st_nxt.rptr) & PTR_MASK;
            st_nxt.flags.empty_n = (used_r != fsc_pkg::PTR_RST); // [RL9]
            st_nxt.flags.almost_empty_n =
                (used_r > fsc_pkg::PTR_W'(st_r.ae_ofs)); // [RL11]

            // Write-side flags see the read pointer late, so they err toward full
            used_w = (st_nxt.wptr - rbin_sync) & PTR_MASK;
            free_w = DEPTH_P - used_w;
            st_nxt.flags.full_n = (used_w != DEPTH_P); // [RL10]
            st_nxt.flags.almost_full_n =
                (free_w > fsc_pkg::PTR_W'(st_r.af_ofs)); // [RL12]

            if (chan_rst) begin
                // Mode strap is caught while reset is held [RL2]
                st_nxt.mode_dual = st_r.s2.we2_ld; // [RL2]
                st_nxt.ofs_sel_w = fsc_pkg::OFS_SEL_AE;
                st_nxt.ofs_sel_r = fsc_pkg::OFS_SEL_AE;
                st_nxt.ae_ofs = fsc_pkg::AE_OFS_RST;
                st_nxt.af_ofs = fsc_pkg::AF_OFS_RST;
                st_nxt.wptr = fsc_pkg::PTR_RST; // [RL13]
                st_nxt.rptr = fsc_pkg::PTR_RST; // [RL13]
                st_nxt.wgray = fsc_pkg::PTR_RST;
                st_nxt.rgray = fsc_pkg::PTR_RST;
                st_nxt.wgray_s1 = fsc_pkg::PTR_RST;
                st_nxt.wgray_s2 = fsc_pkg::PTR_RST;
                st_nxt.rgray_s1 = fsc_pkg::PTR_RST;
                st_nxt.rgray_s2 = fsc_pkg::PTR_RST;
                st_nxt.rd_pend = 1'b0;
                st_nxt.q = fsc_pkg::DATA_RST;
                st_nxt.flags = FLAGS_RST; // [RL13]
                wr_go = 1'b0;
                rd_go = 1'b0;
            end
        end

        always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
                st_r <= '0;
                // Idle strap level keeps the dual-enable mode until a channel reset [RL2]
                st_r.s1 <= PINS_IDLE;
                st_r.s2 <= PINS_IDLE;
                st_r.prev <= PINS_IDLE;
                st_r.mode_dual <= 1'b1;
                st_r.ae_ofs <= fsc_pkg::AE_OFS_RST;
                st_r.af_ofs <= fsc_pkg::AF_OFS_RST;
                st_r.flags <= FLAGS_RST;
            end else begin
                st_r <= st_nxt;
            end
        end

        assign st_out[g] = st_r;
    end

    // Tristate is resolved outside: data and enable both leave from flops [RL15]
    assign chan_a_read_data_o = st_out[0].q;
    assign chan_a_read_data_oe_o = st_out[0].oe;
    assign chan_a_empty_n_o = st_out[0].flags.empty_n;
    assign chan_a_full_n_o = st_out[0].flags.full_n;
    assign chan_a_almost_empty_n_o = st_out[0].flags.almost_empty_n;
    assign chan_a_almost_full_n_o = st_out[0].flags.almost_full_n;
    assign chan_b_read_data_o = st_out[1].q;
    assign chan_b_read_data_oe_o = st_out[1].oe;
    assign chan_b_empty_n_o = st_out[1].flags.empty_n;
    assign chan_b_full_n_o = st_out[1].flags.full_n;
    assign chan_b_almost_empty_n_o = st_out[1].flags.almost_empty_n;
    assign chan_b_almost_full_n_o = st_out[1].flags.almost_full_n;

endmodule : fsc_dual_fifo

`default_nettype wire

// >>> dv/fsc_dual_fifo_chk.sv
`default_nettype none
module fsc_dual_fifo_chk #(
    parameter int DEPTH = 256
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic chan_a_write_clock_i,
    input wire logic chan_a_read_clock_i,
    input wire logic chan_a_output_en_n_i,
    input wire logic chan_a_reset_n_i,
    input wire logic [fsc_pkg::DATA_W-1:0] chan_a_read_data_o,
    input wire logic chan_a_read_data_oe_o,
    input wire logic chan_a_empty_n_o,
    input wire logic chan_a_full_n_o,
    input wire logic chan_a_almost_empty_n_o,
    input wire logic chan_a_almost_full_n_o,
    input wire logic chan_b_write_clock_i,
    input wire logic chan_b_output_en_n_i,
    input wire logic chan_b_read_data_oe_o,
    input wire logic chan_b_empty_n_o,
    input wire logic chan_b_full_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Five samples leave room for the two-flop sync plus the output register
    a_oe_on_a: assert property (!chan_a_output_en_n_i [*5] |-> chan_a_read_data_oe_o)
        else $error("channel A output not driven");
    a_oe_off_a: assert property (chan_a_output_en_n_i [*5] |-> !chan_a_read_data_oe_o)
        else $error("channel A output not released");
    a_oe_on_b: assert property (!chan_b_output_en_n_i [*5] |-> chan_b_read_data_oe_o)
        else $error("channel B output not driven");
    a_flags_excl_a: assert property (chan_a_empty_n_o || chan_a_full_n_o)
        else $error("channel A empty and full together");
    a_flags_excl_b: assert property (chan_b_empty_n_o || chan_b_full_n_o)
        else $error("channel B empty and full together");
    a_ae_empty_a: assert property (!chan_a_empty_n_o |-> !chan_a_almost_empty_n_o)
        else $error("channel A empty but not almost empty");
    a_af_full_a: assert property (!chan_a_full_n_o |-> !chan_a_almost_full_n_o)
        else $error("channel A full but not almost full");
    a_empty_rise_a: assert property (!chan_a_write_clock_i [*8] |=> !$rose(chan_a_empty_n_o))
        else $error("channel A left empty without a write");
    a_empty_rise_b: assert property (!chan_b_write_clock_i [*8] |=> !$rose(chan_b_empty_n_o))
        else $error("channel B left empty without a write");
    a_full_rise_a: assert property ((!chan_a_read_clock_i && chan_a_reset_n_i) [*8]
        |=> !$rose(chan_a_full_n_o)) else $error("channel A left full without a read");
    a_q_hold_a: assert property ((!chan_a_read_clock_i && chan_a_reset_n_i) [*8]
        |=> $stable(chan_a_read_data_o)) else $error("channel A data moved without a read");
    c_full_a: cover property (!chan_a_full_n_o);
    c_af_left_a: cover property (!chan_a_almost_full_n_o ##1 chan_a_almost_full_n_o);
    c_oe_off_a: cover property ($fell(chan_a_read_data_oe_o));
endmodule : fsc_dual_fifo_chk

bind fsc_dual_fifo fsc_dual_fifo_chk #(.DEPTH(DEPTH)) i_chk (.*);
`default_nettype wire

// >>> dv/fsc_ctl_model.sv
`default_nettype none
module fsc_ctl_model (
    input wire logic clk_i,
    output var fsc_pkg::fsc_pins_t pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin clocks low, enables off, output driven, channel reset released
    initial pins_o = 17'h0_7a00;

    // One pin clock period; enables and data stay put while the clock is high
    task automatic pulse(input logic w, input logic [fsc_pkg::DATA_W-1:0] d, input logic [3:0] en);
        @(posedge clk_i);
        {pins_o.we1_n, pins_o.we2_ld, pins_o.re1_n, pins_o.re2_n} <= en;
        pins_o.wdata <= d;
        repeat (3) @(posedge clk_i);
        if (w) pins_o.wclk <= 1'b1;
        else pins_o.rclk <= 1'b1;
        repeat (3) @(posedge clk_i);
        pins_o.wclk <= 1'b0;
        pins_o.rclk <= 1'b0;
        repeat (3) @(posedge clk_i);
        {pins_o.we1_n, pins_o.we2_ld, pins_o.re1_n, pins_o.re2_n} <= 4'hf;
        // Released data shows the inverse so a stale word can never match
        pins_o.wdata <= ~d;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : pulse

    task automatic chan_reset(input logic mode);
        @(posedge clk_i);
        pins_o.rst_n <= 1'b0;
        pins_o.we2_ld <= mode;
        repeat (5) @(posedge clk_i);
        pins_o.rst_n <= 1'b1;
        // Strap held past release so the synced copy is captured intact
        repeat (6) @(posedge clk_i);
        pins_o.we2_ld <= 1'b1;
        #1;
    endtask : chan_reset

    task automatic set_oe(input logic v);
        @(posedge clk_i);
        pins_o.oe_n <= v;
    endtask : set_oe
endmodule : fsc_ctl_model
`default_nettype wire

// >>> dv/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 256;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    fsc_pkg::fsc_pins_t pa;
    fsc_pkg::fsc_pins_t pb;
    wire fsc_pkg::fsc_flags_t fa;
    wire fsc_pkg::fsc_flags_t fb;
    wire logic [fsc_pkg::DATA_W-1:0] qa;
    wire logic [fsc_pkg::DATA_W-1:0] qb;
    wire logic chan_a_output_en_n;
    wire logic chan_b_output_en_n;
    int miscompares = 0;
    int n_compared = 0;
    logic [fsc_pkg::DATA_W-1:0] q_a[$];
    logic [fsc_pkg::DATA_W-1:0] d;
    logic [fsc_pkg::DATA_W-1:0] last;
    logic [3:0] en;

    always #25 clk_sys_i = ~clk_sys_i;

    fsc_ctl_model i_ca (.clk_i(clk_sys_i), .pins_o(pa));
    fsc_ctl_model i_cb (.clk_i(clk_sys_i), .pins_o(pb));

    fsc_dual_fifo #(.DEPTH(DEPTH)) i_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .chan_a_write_clock_i(pa.wclk), .chan_a_read_clock_i(pa.rclk),
        .chan_a_write_data_i(pa.wdata), .chan_a_write_en_primary_n_i(pa.we1_n),
        .chan_a_write_en2_or_load_i(pa.we2_ld), .chan_a_read_en_first_n_i(pa.re1_n),
        .chan_a_read_en_second_n_i(pa.re2_n), .chan_a_output_en_n_i(pa.oe_n),
        .chan_a_reset_n_i(pa.rst_n), .chan_a_read_data_o(qa), .chan_a_read_data_oe_o(chan_a_output_en_n),
        .chan_a_empty_n_o(fa.empty_n), .chan_a_full_n_o(fa.full_n),
        .chan_a_almost_empty_n_o(fa.almost_empty_n), .chan_a_almost_full_n_o(fa.almost_full_n),
        .chan_b_write_clock_i(pb.wclk), .chan_b_read_clock_i(pb.rclk),
        .chan_b_write_data_i(pb.wdata), .chan_b_write_en_primary_n_i(pb.we1_n),
        .chan_b_write_en2_or_load_i(pb.we2_ld), .chan_b_read_en_first_n_i(pb.re1_n),
        .chan_b_read_en_second_n_i(pb.re2_n), .chan_b_output_en_n_i(pb.oe_n),
        .chan_b_reset_n_i(pb.rst_n), .chan_b_read_data_o(qb), .chan_b_read_data_oe_o(chan_b_output_en_n),
        .chan_b_empty_n_o(fb.empty_n), .chan_b_full_n_o(fb.full_n),
        .chan_b_almost_empty_n_o(fb.almost_empty_n), .chan_b_almost_full_n_o(fb.almost_full_n)
    );

    task automatic chk(input logic [fsc_pkg::DATA_W-1:0] got, input logic [fsc_pkg::DATA_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Flag order empty, full, almost empty, almost full; thresholds inclusive
    function automatic logic [3:0] exp_flags(input int used, input int ae, input int af);
        return {used != 0, used != DEPTH, used > ae, DEPTH - used > af};
    endfunction : exp_flags

    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (40000) @(posedge clk_sys_i);
        miscompares++;
        complete_run();
    end

    initial begin
        void'($urandom(32'he86f));
        last = fsc_pkg::DATA_RST;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk(fa, exp_flags(0, 7, 7));
        fork
            i_ca.chan_reset(1'b1);
            i_cb.chan_reset(1'b0);
        join
        // Fill A past full, with two unqualified writes early on
        for (int i = 0; i < DEPTH + 3; i++) begin
            d = 9'($urandom());
            en = (i == 3) ? 4'hf : (i == 5) ? 4'h3 : 4'h7;
            i_ca.pulse(1'b1, d, en);
            if (en == 4'h7 && q_a.size() < DEPTH) q_a.push_back(d);
            chk(fa, exp_flags(q_a.size(), 7, 7));
        end
        while (q_a.size() > 0) begin
            i_ca.pulse(1'b0, 9'h000, 4'hd);
            chk(qa, last);
            i_ca.pulse(1'b0, 9'h000, 4'hc);
            last = q_a.pop_front();
            chk(qa, last);
            chk(fa, exp_flags(q_a.size(), 7, 7));
        end
        i_ca.pulse(1'b0, 9'h000, 4'hc);
        chk(qa, last);
        // Channel B in offset-load mode
        i_cb.pulse(1'b1, 9'h003, 4'h3);
        i_cb.pulse(1'b1, 9'h005, 4'h3);
        i_cb.pulse(1'b0, 9'h000, 4'h8);
        chk(qb, 9'h003);
        i_cb.pulse(1'b0, 9'h000, 4'h8);
        chk(qb, 9'h005);
        chk(fb, exp_flags(0, 3, 5));
        for (int j = 0; j < 6; j++) begin
            d = 9'($urandom());
            if (j == 0) last = d;
            i_cb.pulse(1'b1, d, 4'h7);
            chk(fb, exp_flags(j + 1, 3, 5));
        end
        chk(fa, exp_flags(0, 7, 7));
        i_cb.pulse(1'b0, 9'h000, 4'hc);
        chk(qb, last);
        chk(chan_a_output_en_n, 1'b1);
        i_ca.set_oe(1'b1);
        repeat (6) @(posedge clk_sys_i);
        #1;
        chk(chan_a_output_en_n, 1'b0);
        i_ca.set_oe(1'b0);
        repeat (6) @(posedge clk_sys_i);
        #1;
        chk(chan_a_output_en_n, 1'b1);
        i_cb.chan_reset(1'b1);
        chk(fb, exp_flags(0, 7, 7));
        chk(qb, fsc_pkg::DATA_RST);
        // Dual-enable mode now: a low second pin must not reach the offsets
        i_cb.pulse(1'b0, 9'h000, 4'h8);
        chk(qb, fsc_pkg::DATA_RST);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
